// ===== design/tlb_access_regs.vh
// Constants for the TLB access register block: control register numbers,
// field positions, widths and reset values. Included by the design file.
`ifndef TLB_ACCESS_REGS_VH
`define TLB_ACCESS_REGS_VH

// Control register selectors on the core's control-register port.
`define CTL_SEL_W            3
`define CTL_PAGE_TABLE_ADDR  3'h0
`define CTL_TLB_ENTRY_ACCESS 3'h1
`define CTL_TLB_MISC         3'h2

// Page-table address register layout.
`define PTA_BASE_HI          31
`define PTA_BASE_LO          22
`define PTA_VPN_HI           21
`define PTA_VPN_LO           2
`define VPN_W                20
`define PTA_RESET            32'h00000000

// Entry-access register layout.
`define ACC_SW_HI            31
`define ACC_SW_LO            25
`define ACC_C                24
`define ACC_R                23
`define ACC_W                22
`define ACC_X                21
`define ACC_G                20
`define ACC_PFN_HI           19
`define ACC_PFN_LO           0
`define ACC_HW_W             25
`define ACC_RESET            32'h00000000

// Miscellaneous TLB register fields used here.
`define MISC_WAY_HI          23
`define MISC_WAY_LO          20
`define MISC_RD              19
`define MISC_WE              18
`define MISC_PID_HI          17
`define MISC_PID_LO          4

// TLB geometry: line index width, ways and tag width.
`define PID_W                14
`define LINE_W               4
`define WAY_W                4
`define NUM_WAYS             16
`define TAG_W                16
`define ENTRY_W              55
`define ENTRIES              256

`endif

// ===== design/tlb_access_registers.v
// TLB entry access registers and the TLB array behind them, driven by the
// processor's control register read and write port.
// Assumes the core gives one-cycle write strobes and sequences exceptions.
//
// Functional notes
// [R1] Page table base resets to zero, software read/write, never changed by hardware.
// [R2] Page number loads on fast miss, permission violation, TLB read; software may write.
// [R3] Page number unchanged on exceptions taken while exception-handling flag is one.
// [R4] Write to entry-access register always stores; with write enable it writes TLB.
// [R5] TLB write entry from line bits and way; stores access, page number, process id.
// [R6] Each TLB write increments the way field.
// [R7] Entry-access reads return held value; TLB read flag loads it from the TLB.
// [R8] Software-only bits ignored on write and always read as zero.
// [R9] Cacheable flag zero makes data accesses through the mapping uncacheable.
// [R10] Readable flag zero refuses loads to the mapped memory.
// [R11] Writable flag zero refuses stores to the mapped memory.
// [R12] Executable flag zero refuses instruction fetch from the mapped page.
// [R13] Global flag zero compares process id in lookup; one ignores it.
// [R14] Software writes zero into unused upper frame number bits.
// [R15] Page number and all entry-access fields reset to zero.
// [R16] TLB read loads tag, process id and entry-access from selected entry.
// [R17] Way count is a parameter up to sixteen; way width is fixed at four bits.
// [R18] Base in upper bits, page number below, two lowest bits read as zero.
`timescale 1ns/1ps
`include "tlb_access_regs.vh"

module tlb_access_registers #(
	parameter NUM_WAYS = `NUM_WAYS
) (
	// Clock and reset.
	input  wire                   clk_sys,
	input  wire                   reset,
	// Control register port from the core.
	input  wire                   ctl_write,
	input  wire [`CTL_SEL_W-1:0]  ctl_sel,
	input  wire [31:0]            ctl_wdata,
	output reg  [31:0]            ctl_rdata,
	// Exception events from the core.
	input  wire                   exc_fast_miss,
	input  wire                   exc_perm_violation,
	input  wire                   exception_handling_flag,
	input  wire [`VPN_W-1:0]      exc_vpn,
	// Miscellaneous TLB register fields owned by the core.
	input  wire [`WAY_W-1:0]      way,
	input  wire                   tlb_write_enable,
	input  wire [`PID_W-1:0]      process_identifier,
	// Values the core loads back into its own registers.
	output reg                    way_inc,
	output reg  [`WAY_W-1:0]      next_way,
	output reg                    pid_load,
	output reg  [`PID_W-1:0]      pid_read,
	// Lookup port.
	input  wire [`VPN_W-1:0]      look_vpn,
	input  wire                   look_load,
	input  wire                   look_store,
	input  wire                   look_fetch,
	output reg                    look_hit,
	output reg  [`VPN_W-1:0]      look_pfn,
	output reg                    look_cacheable,
	output reg                    look_refused
);

	// Field registers; the software-only bits are never stored.
	reg [31-`PTA_BASE_LO:0]       page_table_base;
	reg [`VPN_W-1:0]              virtual_page_number;
	reg [`ACC_HW_W-1:0]           tlb_entry_access;
	// Entry layout: {pid, tag, access}.
	reg [`ENTRY_W-1:0]            tlb_mem [0:`ENTRIES-1];
	// One valid bit per entry. The array itself has no reset, so without these
	// a lookup or TLB read of a never-written entry would return unknown bits.
	reg [`ENTRIES-1:0]            entry_valid;

	// Reset images of the two registers, sliced per field below so that no
	// reset value is spelled out twice.
	localparam [31:0]             PTA_RST = `PTA_RESET;
	localparam [31:0]             ACC_RST = `ACC_RESET;

	// Decoded control writes. The TLB read shares the miscellaneous register
	// write; of that write only the read flag and the way field matter here.
	wire [`LINE_W-1:0]            line = virtual_page_number[`LINE_W-1:0];
	wire [`WAY_W+`LINE_W-1:0]     sel_idx = {way, line};
	wire                          wr_pta = ctl_write && (ctl_sel == `CTL_PAGE_TABLE_ADDR);
	wire                          wr_acc = ctl_write && (ctl_sel == `CTL_TLB_ENTRY_ACCESS);
	wire                          tlb_rd = ctl_write && (ctl_sel == `CTL_TLB_MISC) && ctl_wdata[`MISC_RD];
	wire                          tlb_wr = wr_acc && tlb_write_enable;
	// Nested exceptions leave the page number alone, so the handler of the
	// first fault still finds its own page number.
	wire                          exc_load = (exc_fast_miss || exc_perm_violation) && !exception_handling_flag;

	// A TLB read takes its way from the same control write that raises the read
	// flag, so software can name the way and trigger the read in one access.
	wire [`WAY_W-1:0]             rd_way = ctl_wdata[`MISC_WAY_HI:`MISC_WAY_LO];
	wire [`WAY_W+`LINE_W-1:0]     rd_idx = {rd_way, line};
	// Never-written entries read back as all zeros.
	wire [`ENTRY_W-1:0]           rd_entry = entry_valid[rd_idx] ? tlb_mem[rd_idx] : {`ENTRY_W{1'b0}};

	// Way counter wraps at the configured number of ways.
	// Software must keep the way below that number; higher ways are never looked up.
	wire [`WAY_W-1:0]             way_plus = (way == NUM_WAYS - 1) ? {`WAY_W{1'b0}} : way + 1'b1; // R17

	// Page-table address register; the base field is software only.
	always @(posedge clk_sys) begin
		if (reset) begin
			page_table_base <= PTA_RST[`PTA_BASE_HI:`PTA_BASE_LO]; // R1
			virtual_page_number <= PTA_RST[`PTA_VPN_HI:`PTA_VPN_LO]; // R15
		end else begin
			if (wr_pta) begin
				page_table_base <= ctl_wdata[`PTA_BASE_HI:`PTA_BASE_LO]; // R1
			end
			// Priority: TLB read, then exception, then software write.
			if (tlb_rd) begin
				virtual_page_number <= {rd_entry[`ACC_HW_W+`TAG_W-1:`ACC_HW_W], line}; // R16
			end else if (exc_load) begin
				virtual_page_number <= exc_vpn; // R2 R3
			end else if (wr_pta) begin
				virtual_page_number <= ctl_wdata[`PTA_VPN_HI:`PTA_VPN_LO]; // R2
			end
		end
	end

	// Entry-access register and TLB write path.
	always @(posedge clk_sys) begin
		if (reset) begin
			tlb_entry_access <= ACC_RST[`ACC_HW_W-1:0]; // R15
			way_inc <= 1'b0;
			next_way <= 4'h0;
			pid_load <= 1'b0;
			pid_read <= 14'h0000;
		end else begin
			way_inc <= tlb_wr; // R6
			next_way <= way_plus; // R6
			pid_load <= tlb_rd;
			if (tlb_rd) begin
				tlb_entry_access <= rd_entry[`ACC_HW_W-1:0]; // R7 R16
				pid_read <= rd_entry[`ENTRY_W-1:`ACC_HW_W+`TAG_W]; // R16
			end else if (wr_acc) begin
				tlb_entry_access <= ctl_wdata[`ACC_HW_W-1:0]; // R4 R8
			end
		end
	end

	// Entry array write; the stored tag is the page number above the line bits.
	// The access bits come straight from the write data, so entry and register agree.
	always @(posedge clk_sys) begin
		if (tlb_wr) begin
			tlb_mem[sel_idx] <= {process_identifier, virtual_page_number[`VPN_W-1:`LINE_W],
				ctl_wdata[`ACC_HW_W-1:0]}; // R5
		end
	end

	// Valid bits follow every TLB write; only reset clears them, as the
	// block has no invalidate operation of its own.
	always @(posedge clk_sys) begin
		if (reset) begin
			entry_valid <= {`ENTRIES{1'b0}};
		end else if (tlb_wr) begin
			entry_valid[sel_idx] <= 1'b1; // R5
		end
	end

	// Read mux; software-only and reserved bits return zero.
	// Data is registered, so it answers one cycle after the select changes.
	always @(posedge clk_sys) begin
		if (reset) begin
			ctl_rdata <= 32'h00000000;
		end else begin
			case (ctl_sel)
			`CTL_PAGE_TABLE_ADDR: ctl_rdata <= {page_table_base, virtual_page_number, 2'h0}; // R18
			`CTL_TLB_ENTRY_ACCESS: ctl_rdata <= {7'h00, tlb_entry_access}; // R7 R8
			default: ctl_rdata <= 32'h00000000;
			endcase
		end
	end

	// Lookup across all ways of the selected line, one match bit per way.
	wire [`NUM_WAYS-1:0]          way_hit;
	wire [`ACC_HW_W-1:0]          way_acc [0:`NUM_WAYS-1];
	genvar g;
	generate
		for (g = 0; g < `NUM_WAYS; g = g + 1) begin : gen_way
			// A genvar cannot be part-selected, so the way number is held in a sized constant.
			localparam [31:0] WAY_NUM = g;
			wire [`WAY_W+`LINE_W-1:0] idx = {WAY_NUM[`WAY_W-1:0], look_vpn[`LINE_W-1:0]};
			wire [`ENTRY_W-1:0] e = tlb_mem[idx];
			wire pid_ok = e[`ACC_G] || (e[`ENTRY_W-1:`ACC_HW_W+`TAG_W] == process_identifier); // R13
			assign way_hit[g] = (g < NUM_WAYS) && entry_valid[idx] && pid_ok &&
				(e[`ACC_HW_W+`TAG_W-1:`ACC_HW_W] == look_vpn[`VPN_W-1:`LINE_W]);
			assign way_acc[g] = e[`ACC_HW_W-1:0];
		end
	endgenerate

	// Priority pick of the lowest matching way.
	// Software should keep tags distinct per line; if it does not, the lowest way wins.
	reg [`ACC_HW_W-1:0]           hit_acc;
	integer i;
	always @* begin
		hit_acc = {`ACC_HW_W{1'b0}};
		for (i = `NUM_WAYS - 1; i >= 0; i = i - 1) begin
			if (way_hit[i]) begin
				hit_acc = way_acc[i];
			end
		end
	end

	// Registered lookup result with permission checks.
	// Refusal is raised only on a hit; a miss is the core's fast-miss path,
	// not a permission fault.
	always @(posedge clk_sys) begin
		if (reset) begin
			look_hit <= 1'b0;
			look_pfn <= 20'h00000;
			look_cacheable <= 1'b0;
			look_refused <= 1'b0;
		end else begin
			look_hit <= |way_hit;
			look_pfn <= hit_acc[`ACC_PFN_HI:`ACC_PFN_LO];
			look_cacheable <= hit_acc[`ACC_C]; // R9
			look_refused <= (|way_hit) && ((look_load && !hit_acc[`ACC_R]) || // R10
				(look_store && !hit_acc[`ACC_W]) || // R11
				(look_fetch && !hit_acc[`ACC_X])); // R12
		end
	end

endmodule

// ===== bench/tlb_regs_monitor.sv
// Assertions on the TLB access register block ports.
// Bound from the testbench top; NUM_WAYS follows the design.
`timescale 1ns/1ps
module tlb_regs_monitor #(parameter NUM_WAYS = 16) (
	input wire logic        clk_sys, reset, ctl_write, tlb_write_enable,
	input wire logic        way_inc, pid_load, look_hit, look_refused,
	input wire logic [2:0]  ctl_sel,
	input wire logic [31:0] ctl_wdata, ctl_rdata,
	input wire logic [3:0]  way, next_way
);
	// One clock domain, so clock and reset are given once.
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);
	a_sw_bits_zero: assert property ($past(ctl_sel) == 3'h1 |-> ctl_rdata[31:25] == 7'h00)
		else $error("software-only bits read nonzero");
	a_pta_low_zero: assert property ($past(ctl_sel) == 3'h0 |-> ctl_rdata[1:0] == 2'h0)
		else $error("reserved address bits read nonzero");
	a_tlb_write_pulse: assert property (ctl_write && ctl_sel == 3'h1 && tlb_write_enable |=> way_inc)
		else $error("no way increment after TLB write");
	a_way_inc_cause: assert property (way_inc |-> $past(ctl_write && ctl_sel == 3'h1 && tlb_write_enable))
		else $error("way increment without TLB write");
	a_way_wrap: assert property (way_inc |-> next_way == (($past(way) == NUM_WAYS - 1) ? 4'h0 : $past(way) + 4'h1))
		else $error("wrong next way");
	a_tlb_read_pulse: assert property (ctl_write && ctl_sel == 3'h2 && ctl_wdata[19] |=> pid_load)
		else $error("no load after TLB read");
	a_pid_load_cause: assert property (pid_load |-> $past(ctl_write && ctl_sel == 3'h2 && ctl_wdata[19]))
		else $error("load without TLB read");
	a_refused_hit: assert property (look_refused |-> look_hit)
		else $error("refusal without hit");
endmodule

// ===== bench/core_misc_model.sv
// Model of the core's miscellaneous TLB register fields.
// Written by control writes to selector 2; loaded back by the block.
`timescale 1ns/1ps
module core_misc_model (
	// Clock, reset and control port.
	input wire        clk_sys, reset, ctl_write,
	input wire [2:0]  ctl_sel,
	input wire [31:0] ctl_wdata,
	// Loads from the block.
	input wire        way_inc, pid_load,
	input wire [3:0]  next_way,
	input wire [13:0] pid_read,
	// Held fields.
	output reg [3:0]  way,
	output reg        tlb_write_enable,
	output reg [13:0] process_identifier
);
	// Later statements win, so a TLB read beats the software value.
	always @(posedge clk_sys) begin
		if (reset) begin
			way <= 4'h0;
			tlb_write_enable <= 1'b0;
			process_identifier <= 14'h0000;
		end else begin
			if (ctl_write && ctl_sel == 3'h2) begin
				way <= ctl_wdata[23:20];
				tlb_write_enable <= ctl_wdata[18];
				process_identifier <= ctl_wdata[17:4];
			end
			if (way_inc) way <= next_way;
			if (pid_load) process_identifier <= pid_read;
		end
	end
endmodule

// ===== bench/tb.sv
// Testbench top for the TLB access register block and core model.
// Assumes the design header is on the include path.
`timescale 1ns/1ps
module tb;
	reg         clk_sys, reset, ctl_write, exc_fast_miss, exc_perm_violation;
	reg         exception_handling_flag, look_load, look_store, look_fetch;
	reg  [2:0]  ctl_sel;
	reg  [31:0] ctl_wdata;
	reg  [19:0] exc_vpn, look_vpn;
	wire [31:0] ctl_rdata;
	wire [19:0] look_pfn;
	wire [13:0] process_identifier, pid_read;
	wire [3:0]  way, next_way;
	wire        tlb_write_enable, way_inc, pid_load, look_hit, look_cacheable, look_refused;
	integer     mismatches = 0, total_checks = 0, i;
	tlb_access_registers #(.NUM_WAYS(4)) u_dut (.clk_sys, .reset, .ctl_write, .ctl_sel, .ctl_wdata, .ctl_rdata,
		.exc_fast_miss, .exc_perm_violation, .exception_handling_flag, .exc_vpn, .way, .tlb_write_enable,
		.process_identifier, .way_inc, .next_way, .pid_load, .pid_read, .look_vpn, .look_load, .look_store,
		.look_fetch, .look_hit, .look_pfn, .look_cacheable, .look_refused);
	core_misc_model u_core (.clk_sys, .reset, .ctl_write, .ctl_sel, .ctl_wdata, .way_inc, .pid_load, .next_way,
		.pid_read, .way, .tlb_write_enable, .process_identifier);
	// Free-running 200 MHz clock.
	initial begin
		clk_sys = 0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	task end_sim; begin
		if (mismatches == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	end endtask
	task chk(input ok, input [63:0] m); begin
		total_checks = total_checks + 1;
		if (!ok) begin
			mismatches = mismatches + 1;
			$display("CHECK FAILED %0t %0s", $time, m);
		end
	end endtask
	// An idle edge follows each write so the strobe is never raised twice at once.
	task wr(input [2:0] s, input [31:0] d); begin
		ctl_sel = s;
		ctl_wdata = d;
		ctl_write = 1;
		@(posedge clk_sys);
		#1 ctl_write = 0;
		@(posedge clk_sys);
		#1;
	end endtask
	task rd(input [2:0] s, input [31:0] e); begin
		ctl_sel = s;
		repeat (2) @(posedge clk_sys);
		#1 chk(ctl_rdata === e, "rdata");
	end endtask
	task ex(input f, input p, input h, input [19:0] v, input [19:0] e); begin
		{exc_fast_miss, exc_perm_violation, exception_handling_flag, exc_vpn} = {f, p, h, v};
		@(posedge clk_sys);
		#1 {exc_fast_miss, exc_perm_violation} = 2'h0;
		rd(0, {10'h2A5, e, 2'h0});
	end endtask
	// Main sequence; the reset takes twelve edges.
	initial begin
		{reset, ctl_write, exc_fast_miss, exc_perm_violation, exception_handling_flag} = 5'h10;
		{look_load, look_store, look_fetch, ctl_sel, ctl_wdata, exc_vpn, look_vpn} = 0;
		repeat (12) @(posedge clk_sys);
		#1 reset = 0;
		rd(0, 0);
		rd(1, 0);
		wr(0, {10'h2A5, 20'h12345, 2'h3});
		rd(0, {10'h2A5, 20'h12345, 2'h0});
		wr(2, 32'h00340150);
		for (i = 0; i < 4; i = i + 1) wr(1, 32'hFD123456);
		rd(1, 32'h01123456);
		chk(way === 4'h3, "way");
		wr(2, 32'h00300000);
		wr(1, 0);
		wr(0, {10'h2A5, 20'h00005, 2'h0});
		wr(2, 32'h00380000);
		rd(1, 32'h01123456);
		rd(0, {10'h2A5, 20'h12345, 2'h0});
		chk(process_identifier === 14'h0015, "pid");
		wr(2, 32'h00000FF0);
		look_vpn = 20'h12345;
		for (i = 0; i < 3; i = i + 1) begin
			{look_load, look_store, look_fetch} = 3'h4 >> i;
			repeat (2) @(posedge clk_sys);
			#1 chk(look_hit === 1 && look_refused === 1 && look_pfn === 20'h23456 && look_cacheable === 1, "look");
		end
		// Second entry: uncacheable, all access allowed, bound to one process.
		wr(0, {10'h2A5, 20'h00016, 2'h0});
		wr(2, 32'h00040FF0);
		wr(1, 32'h00E0ABCD);
		look_vpn = 20'h00016;
		for (i = 0; i < 3; i = i + 1) begin
			{look_load, look_store, look_fetch} = 3'h4 >> i;
			repeat (2) @(posedge clk_sys);
			#1 chk(look_hit === 1 && look_refused === 0 && look_pfn === 20'h0ABCD && look_cacheable === 0, "allow");
		end
		wr(2, 32'h00100010);
		repeat (2) @(posedge clk_sys);
		#1 chk(look_hit === 0 && look_refused === 0, "miss");
		// Read way 0 back while the held way is 1: the read names its own way.
		wr(1, 0);
		wr(2, 32'h00080000);
		rd(1, 32'h00E0ABCD);
		rd(0, {10'h2A5, 20'h00016, 2'h0});
		chk(process_identifier === 14'h00FF, "pid");
		ex(1, 0, 0, 20'hABCDE, 20'hABCDE);
		ex(0, 1, 0, 20'h54321, 20'h54321);
		ex(1, 0, 1, 20'h0F0F0, 20'h54321);
		// Reset again in mid-run: both registers must come back as zero.
		reset = 1;
		repeat (12) @(posedge clk_sys);
		#1 reset = 0;
		rd(0, 0);
		rd(1, 0);
		end_sim;
	end
	// Watchdog well past the expected run length.
	initial begin
		#20000;
		mismatches = mismatches + 1;
		end_sim;
	end
endmodule
bind tlb_access_registers tlb_regs_monitor #(.NUM_WAYS(NUM_WAYS)) u_mon (.clk_sys, .reset, .ctl_write,
	.tlb_write_enable, .way_inc, .pid_load, .look_hit, .look_refused, .ctl_sel, .ctl_wdata, .ctl_rdata, .way, .next_way);
